// ===== test/amd_mem_model.sv
// Program memory model that answers the decoder's indirect pointer byte reads
`timescale 1ns/1ns
module amd_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_rd_req,
  input wire logic [14:0] mem_addr,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [3:0] wait_reg;

  // Answer after lat idle cycles; the data is registered, so a gap follows each ack
  // to see the stepped address before answering again (no back-to-back acks)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      wait_reg <= 4'h0;
    end else if (mem_rd_req && !mem_ack && wait_reg >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_addr[7:0] ^ 8'ha5;
      wait_reg <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // Data not held between answers
      if (mem_rd_req && !mem_ack) begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

// ===== test/amd_top_bench.sv
// Self-checking bench for the addressing mode decoder
`timescale 1ns/1ns
module amd_top_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack, mem_rd_req, err;
  logic [7:0] paddr, mem_rdata;
  logic [31:0] pwdata, prdata, rd_q, st, op;
  logic [14:0] mem_addr;
  logic [1:0] page_bits;
  logic [3:0] lat;
  int error_cnt, cmp_count;

  amd_top amd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_rd_req(mem_rd_req),
    .mem_addr(mem_addr), .page_bits(page_bits));
  amd_mem_model amd_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_rd_req(mem_rd_req),
    .mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd_q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  function automatic logic [31:0] ins(input logic [2:0] m, input logic two,
    input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    return {4'h0, two, m, b2, b1, b0};
  endfunction

  function automatic logic [7:0] gv(input int i);
    return 8'(i * 17 + 5);
  endfunction

  // Start one decode, poll status until idle, then fetch the operands
  task automatic exec(input logic [31:0] i);
    int n;
    n = 0;
    apb(1'b1, amd_pkg::AMD_OFF_INSTR, i);
    do begin
      apb(1'b0, amd_pkg::AMD_OFF_STAT, 32'h0);
      n++;
    end while (rd_q[18] !== 1'b0 && n < 20);
    st = rd_q;
    if (rd_q[18] !== 1'b0) begin
      error_cnt++;
      print_verdict();
    end
    apb(1'b0, amd_pkg::AMD_OFF_OPND, 32'h0);
    op = rd_q;
    chk(32'(st[19]), 32'h1);
  endtask

  task automatic gpr_set(input logic [2:0] i, input logic [7:0] v);
    apb(1'b1, amd_pkg::AMD_OFF_GPR, {21'h0, i, v});
  endtask

  // Reset state and an unmapped address
  task automatic t_reset();
    chk(32'(page_bits), 32'h0);
    apb(1'b0, amd_pkg::AMD_OFF_STAT, 32'h0);
    chk(32'(rd_q[17:16]), 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd_q, 32'h0);
  endtask

  // Every register field in both banks, one and two operands
  task automatic t_regs();
    logic [2:0] ph;
    for (int i = 0; i < 7; i++) gpr_set(3'(i), gv(i));
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, amd_pkg::AMD_OFF_CTRL, 32'(b));
      for (int f = 0; f < 4; f++) begin
        ph = (f == 0) ? 3'h0 : 3'(f + 3 * b);
        exec(ins(amd_pkg::AMD_M_REG, 1'b0, 8'(f), 8'h00, 8'h00));
        chk(32'(st[22:20]), 32'(ph));
        chk(32'(op[7:0]), 32'(gv(ph)));
        exec(ins(amd_pkg::AMD_M_REG, 1'b1, 8'(f), 8'h00, 8'h00));
        chk(32'(op[7:0]), 32'(gv(0)));
        chk(32'(op[15:8]), 32'(gv(ph)));
      end
    end
    apb(1'b1, amd_pkg::AMD_OFF_CTRL, 32'h0);
  endtask

  // Immediate, relative extremes and page-zero relative wrap
  task automatic t_rel();
    exec(ins(amd_pkg::AMD_M_IMM, 1'b0, 8'h01, 8'h9c, 8'h00));
    chk(32'(op[15:8]), 32'h9c);
    apb(1'b1, amd_pkg::AMD_OFF_PC, 32'h2100);
    exec(ins(amd_pkg::AMD_M_REL, 1'b0, 8'h00, 8'h3f, 8'h00));
    chk(32'(st[14:0]), 32'h2141);
    exec(ins(amd_pkg::AMD_M_REL, 1'b0, 8'h00, 8'h40, 8'h00));
    chk(32'(st[14:0]), 32'h20c2);
    exec(ins(amd_pkg::AMD_M_ZREL, 1'b0, 8'h00, 8'h3f, 8'h00));
    chk(32'(st[14:0]), 32'h003f);
    exec(ins(amd_pkg::AMD_M_ZREL, 1'b0, 8'h00, 8'h40, 8'h00));
    chk(32'(st[14:0]), 32'h1fc0);
  endtask

  // Absolute branch loads page; non-branch stays in page; interrupt clears it
  task automatic t_abs();
    exec(ins(amd_pkg::AMD_M_ABR, 1'b0, 8'h00, 8'h6a, 8'h34));
    chk(32'(st[14:0]), 32'h6a34);
    chk(32'(page_bits), 32'h3);
    exec(ins(amd_pkg::AMD_M_ANB, 1'b0, 8'h01, 8'h0b, 8'h77));
    chk(32'(st[14:0]), 32'h6b77);
    chk(32'(st[22:20]), 32'h1);
    chk(32'(page_bits), 32'h3);
    apb(1'b1, amd_pkg::AMD_OFF_CTRL, 32'h2);
    // The clear lands at the edge that ends the transfer; look one edge later
    @(posedge pclk);
    chk(32'(page_bits), 32'h0);
  endtask

  // Index control codes increment, decrement and index-only (not none), with pre-modify and writeback
  task automatic t_index();
    logic [7:0] x;
    for (int c = 1; c < 4; c++) begin
      x = (c == 1) ? 8'h41 : (c == 2) ? 8'h3f : 8'h40;
      gpr_set(3'h2, 8'h40);
      exec(ins(amd_pkg::AMD_M_ANB, 1'b0, 8'h02, {1'b0, 2'(c), 5'h1f}, 8'h80));
      chk(32'(st[14:0]), 32'h1f80 + 32'(x));
      chk({st[27], 3'h0, st[26:24], 1'b0, st[22:20]}, 32'h420);
      chk(32'(op[7:0]), 32'(gv(0)));
      apb(1'b0, amd_pkg::AMD_OFF_GPR, 32'h0);
      chk(32'(rd_q[7:0]), 32'(x));
    end
  endtask

  // Indirect fetches at several memory latencies, then a mid-run reset
  task automatic t_ind();
    lat <= 4'h3;
    // A second instruction during the pointer fetch is refused
    apb(1'b1, amd_pkg::AMD_OFF_INSTR, ins(amd_pkg::AMD_M_REL, 1'b0, 8'h00, 8'h85, 8'h00));
    apb(1'b1, amd_pkg::AMD_OFF_INSTR, ins(amd_pkg::AMD_M_IMM, 1'b0, 8'h01, 8'h9c, 8'h00));
    chk({31'h0, err}, 32'h1);
    exec(ins(amd_pkg::AMD_M_REL, 1'b0, 8'h00, 8'h85, 8'h00));
    chk(32'(st[14:0]), 32'h22ad);
    chk(32'(page_bits), 32'h0);
    lat <= 4'h0;
    gpr_set(3'h2, 8'h40);
    exec(ins(amd_pkg::AMD_M_ANB, 1'b0, 8'h02, 8'he1, 8'h10));
    chk(32'(st[14:0]), 32'h35f4);
    lat <= 4'h1;
    exec(ins(amd_pkg::AMD_M_ABR, 1'b0, 8'h00, 8'h81, 8'h60));
    chk(32'(st[14:0]), 32'h45c4);
    chk(32'(page_bits), 32'h2);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(page_bits), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, amd_pkg::AMD_OFF_STAT, 32'h0);
    chk(rd_q, 32'h0);
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 4'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_rel();
    t_abs();
    t_index();
    t_ind();
    print_verdict();
  end
endmodule

// ===== verilog/amd_dec_if.sv
// Decoded instruction fields passed from field decoder to core
`timescale 1ns/1ns
interface amd_dec_if;
  logic [23:0] instr;
  logic [14:0] pc;
  logic [1:0] page;
  logic [1:0] reg_fld;
  logic ind;
  logic [1:0] idx_ctl;
  logic [7:0] imm;
  logic [14:0] addr15;
  logic [14:0] abs13_ea;
  logic [14:0] rel_ea;
  logic [14:0] zrel_ea;
  modport dec (input instr, pc, page, output reg_fld, ind, idx_ctl, imm, addr15,
    abs13_ea, rel_ea, zrel_ea);
  modport core (output instr, pc, page, input reg_fld, ind, idx_ctl, imm, addr15,
    abs13_ea, rel_ea, zrel_ea);
endinterface

// ===== verilog/amd_field_dec.sv
// Combinational split of instruction bytes into address fields
`timescale 1ns/1ns
module amd_field_dec (
  amd_dec_if.dec d
);
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [12:0] disp13;
  logic [12:0] next13;

  // Byte split and displacement sign extension
  always_comb begin
    b0 = d.instr[7:0];
    b1 = d.instr[15:8];
    b2 = d.instr[23:16];
    d.reg_fld = b0[1:0];
    d.imm = b1;
    d.ind = b1[amd_pkg::AMD_IND_BIT];
    d.idx_ctl = b1[6:5];
    d.addr15 = {b1[6:0], b2};
    d.abs13_ea = {d.page, b1[4:0], b2};
    disp13 = {{6{b1[6]}}, b1[6:0]};
    // Relative target stays in the page of the instruction
    next13 = d.pc[12:0] + amd_pkg::AMD_REL_STEP[12:0];
    d.rel_ea = {d.pc[14:13], next13 + disp13};
    // Negative displacement wraps to the top of page 0
    d.zrel_ea = {2'h0, disp13};
  end
endmodule

// ===== verilog/amd_pkg.sv
// Shared constants, types and helpers of the addressing mode decoder
package amd_pkg;
  // APB register offsets (byte addresses)
  localparam logic [7:0] AMD_OFF_CTRL = 8'h00;
  localparam logic [7:0] AMD_OFF_INSTR = 8'h04;
  localparam logic [7:0] AMD_OFF_PC = 8'h08;
  localparam logic [7:0] AMD_OFF_GPR = 8'h0c;
  localparam logic [7:0] AMD_OFF_STAT = 8'h10;
  localparam logic [7:0] AMD_OFF_OPND = 8'h14;
  // Field positions
  localparam int AMD_CTRL_BANK = 0;
  localparam int AMD_CTRL_IRQ = 1;
  localparam int AMD_INS_MODE_LSB = 24;
  localparam int AMD_INS_TWO_OP = 27;
  localparam int AMD_GPR_SEL_LSB = 8;
  localparam int AMD_IND_BIT = 7;
  // Widths
  localparam int AMD_AW = 15;
  localparam int AMD_PW = 13;
  localparam int AMD_NREGS = 7;
  localparam logic [2:0] AMD_R0 = 3'h0;
  localparam logic [2:0] AMD_BANK1_OFS = 3'h3;
  localparam logic [7:0] AMD_ONE = 8'h01;
  localparam logic [14:0] AMD_REL_STEP = 15'h0002;
  // Index control codes
  localparam logic [1:0] AMD_IX_NONE = 2'h0;
  localparam logic [1:0] AMD_IX_INC = 2'h1;
  localparam logic [1:0] AMD_IX_DEC = 2'h2;
  localparam logic [1:0] AMD_IX_ONLY = 2'h3;
  localparam logic [1:0] AMD_REG_ZERO = 2'h0;
  // Addressing modes as software writes them
  localparam logic [2:0] AMD_M_REG = 3'h0;
  localparam logic [2:0] AMD_M_IMM = 3'h1;
  localparam logic [2:0] AMD_M_REL = 3'h2;
  localparam logic [2:0] AMD_M_ZREL = 3'h3;
  localparam logic [2:0] AMD_M_ABR = 3'h4;
  localparam logic [2:0] AMD_M_ANB = 3'h5;

  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_IND_HI, ST_IND_LO} amd_state_t;

  // Register field plus bank select to physical register index
  function automatic logic [2:0] amd_phys(input logic [1:0] fld, input logic bank);
    if (fld == AMD_REG_ZERO) begin
      return AMD_R0;
    end
    return {1'b0, fld} + (bank ? AMD_BANK1_OFS : AMD_R0);
  endfunction
endpackage

// ===== verilog/amd_regfile.sv
// Seven general-purpose registers: register zero plus two banks of three
`timescale 1ns/1ns
module amd_regfile #(
  parameter int NREGS = amd_pkg::AMD_NREGS,
  parameter int DW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [2:0] raddr,
  output logic [DW-1:0] rdata,
  output logic [DW-1:0] r0data
);
  logic [DW-1:0] mem_reg [NREGS];
  logic [DW-1:0] mem_next [NREGS];

  if (NREGS < 1 || NREGS > 8 || DW < 1) begin : g_bad
    $error("amd_regfile: NREGS must be 1..8 and DW positive");
  end

  // Write port
  always_comb begin
    for (int i = 0; i < NREGS; i++) begin
      mem_next[i] = mem_reg[i];
      if (we && waddr == 3'(i)) begin
        mem_next[i] = wdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREGS; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

  // Out-of-range read answers zero
  assign rdata = ({1'b0, raddr} < 4'(NREGS)) ? mem_reg[raddr] : '0;
  assign r0data = mem_reg[0];
endmodule

// ===== verilog/amd_top.sv
// Addressing mode decoder with APB register access and indirect fetch port
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
module amd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic mem_rd_req,
  output logic [14:0] mem_addr,
  output logic [1:0] page_bits
);
  amd_dec_if d ();
  amd_field_dec u_dec (.d(d));

  amd_pkg::amd_state_t st_reg, st_next;
  logic [27:0] instr_reg, instr_next;
  logic [14:0] pc_reg, pc_next;
  logic bank_reg, bank_next;
  logic [1:0] page_reg, page_next;
  logic [14:0] ea_reg, ea_next;
  logic [7:0] hi_reg, hi_next;
  logic [7:0] idx_reg, idx_next;
  logic [7:0] opa_reg, opa_next;
  logic [7:0] opb_reg, opb_next;
  logic [2:0] op_sel_reg, op_sel_next;
  logic [2:0] idx_sel_reg, idx_sel_next;
  logic idx_on_reg, idx_on_next;
  logic done_reg, done_next;
  logic req_reg, req_next;
  logic [14:0] maddr_reg, maddr_next;
  logic [2:0] gpr_sel_reg, gpr_sel_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  logic [2:0] mode;
  logic [2:0] fphys;
  logic [14:0] ptr;
  logic [14:0] full;
  logic [7:0] rf_a;
  logic [7:0] rf_r0;
  logic [2:0] rf_raddr;
  logic rf_we;
  logic [2:0] rf_waddr;
  logic [7:0] rf_wdata;
  logic acc;
  logic fin;
  logic wr_ctrl;
  logic wr_instr;
  logic wr_gpr;
  logic irq_acc;
  logic busy;

  amd_regfile u_rf (
    .pclk(pclk),
    .presetn(presetn),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .raddr(rf_raddr),
    .rdata(rf_a),
    .r0data(rf_r0)
  );

  // Decoder inputs
  assign d.instr = instr_reg[23:0];
  assign d.pc = pc_reg;
  assign d.page = page_reg;
  assign mode = instr_reg[amd_pkg::AMD_INS_MODE_LSB +: 3];
  assign fphys = amd_pkg::amd_phys(d.reg_fld, bank_reg);
  assign busy = (st_reg != amd_pkg::ST_IDLE);

  // APB phase decode; writes land on the edge where pready is seen high
  assign acc = psel & penable & ~pready_reg;
  assign fin = psel & penable & pready_reg;
  assign wr_ctrl = fin & pwrite & (paddr == amd_pkg::AMD_OFF_CTRL);
  assign wr_instr = fin & pwrite & (paddr == amd_pkg::AMD_OFF_INSTR) & ~busy;
  assign wr_gpr = fin & pwrite & (paddr == amd_pkg::AMD_OFF_GPR);
  assign irq_acc = wr_ctrl & pwdata[amd_pkg::AMD_CTRL_IRQ];

  // APB answer: one wait state, data prepared in the first access cycle
  always_comb begin
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (acc) begin
      pready_next = 1'b1;
      prdata_next = '0;
      case (paddr)
        amd_pkg::AMD_OFF_CTRL: prdata_next = {31'h0, bank_reg};
        amd_pkg::AMD_OFF_INSTR: prdata_next = {4'h0, instr_reg};
        amd_pkg::AMD_OFF_PC: prdata_next = {17'h0, pc_reg};
        amd_pkg::AMD_OFF_GPR: prdata_next = {21'h0, gpr_sel_reg, rf_a};
        amd_pkg::AMD_OFF_STAT: prdata_next = {4'h0, idx_on_reg, idx_sel_reg, 1'b0,
          op_sel_reg, done_reg, busy, page_reg, 1'b0, ea_reg};
        amd_pkg::AMD_OFF_OPND: prdata_next = {16'h0, opb_reg, opa_reg};
        default: pslverr_next = 1'b1;
      endcase
      // A new instruction while one is in flight is refused
      if (pwrite && busy && paddr == amd_pkg::AMD_OFF_INSTR) begin
        pslverr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Register file port sharing: core index writeback, else APB writes
  always_comb begin
    rf_raddr = busy ? fphys : gpr_sel_reg;
    rf_we = wr_gpr;
    rf_waddr = pwdata[amd_pkg::AMD_GPR_SEL_LSB +: 3];
    rf_wdata = pwdata[7:0];
    if (st_reg == amd_pkg::ST_CALC && mode == amd_pkg::AMD_M_ANB &&
        (d.idx_ctl == amd_pkg::AMD_IX_INC || d.idx_ctl == amd_pkg::AMD_IX_DEC)) begin
      rf_we = 1'b1;
      rf_waddr = fphys;
      rf_wdata = idx_next;
    end
  end

  // Decode sequencer: compute address, optionally fetch indirect pointer
  always_comb begin
    st_next = st_reg;
    instr_next = instr_reg;
    pc_next = pc_reg;
    bank_next = bank_reg;
    page_next = page_reg;
    ea_next = ea_reg;
    hi_next = hi_reg;
    idx_next = idx_reg;
    opa_next = opa_reg;
    opb_next = opb_reg;
    op_sel_next = op_sel_reg;
    idx_sel_next = idx_sel_reg;
    idx_on_next = idx_on_reg;
    done_next = done_reg;
    req_next = req_reg;
    maddr_next = maddr_reg;
    gpr_sel_next = gpr_sel_reg;
    ptr = d.abs13_ea;
    full = {hi_reg[6:0], mem_rdata};
    if (wr_ctrl) begin
      bank_next = pwdata[amd_pkg::AMD_CTRL_BANK];
    end
    if (fin && pwrite && paddr == amd_pkg::AMD_OFF_PC) begin
      pc_next = pwdata[14:0];
    end
    if (wr_gpr) begin
      gpr_sel_next = pwdata[amd_pkg::AMD_GPR_SEL_LSB +: 3];
    end
    case (st_reg)
      amd_pkg::ST_IDLE: begin
        if (wr_instr) begin
          instr_next = pwdata[27:0];
          done_next = 1'b0;
          idx_on_next = 1'b0;
          st_next = amd_pkg::ST_CALC;
        end
      end
      amd_pkg::ST_CALC: begin
        op_sel_next = fphys;
        opa_next = rf_a;
        opb_next = rf_a;
        case (mode)
          amd_pkg::AMD_M_IMM: opb_next = d.imm;
          amd_pkg::AMD_M_REL: ptr = d.rel_ea;
          amd_pkg::AMD_M_ZREL: ptr = d.zrel_ea;
          amd_pkg::AMD_M_ABR: ptr = d.addr15;
          amd_pkg::AMD_M_ANB: begin
            if (d.idx_ctl != amd_pkg::AMD_IX_NONE) begin
              // Index register named by the field, operand moves to register zero
              idx_on_next = 1'b1;
              idx_sel_next = fphys;
              op_sel_next = amd_pkg::AMD_R0;
              opa_next = rf_r0;
              case (d.idx_ctl)
                amd_pkg::AMD_IX_INC: idx_next = rf_a + amd_pkg::AMD_ONE;
                amd_pkg::AMD_IX_DEC: idx_next = rf_a - amd_pkg::AMD_ONE;
                default: idx_next = rf_a;
              endcase
              // Unsigned index added inside the current page
              if (!d.ind) begin
                ptr = {page_reg, d.abs13_ea[12:0] + {5'h0, idx_next}};
              end
            end
          end
          default: begin
            // Two-operand form: register zero plus the named register
            if (instr_reg[amd_pkg::AMD_INS_TWO_OP]) begin
              op_sel_next = amd_pkg::AMD_R0;
              opa_next = rf_r0;
            end
          end
        endcase
        if (mode == amd_pkg::AMD_M_REG || mode == amd_pkg::AMD_M_IMM) begin
          done_next = 1'b1;
          st_next = amd_pkg::ST_IDLE;
        end else if (d.ind) begin
          req_next = 1'b1;
          maddr_next = ptr;
          st_next = amd_pkg::ST_IND_HI;
        end else begin
          ea_next = ptr;
          if (mode == amd_pkg::AMD_M_ABR) begin
            page_next = ptr[14:13];
          end
          done_next = 1'b1;
          st_next = amd_pkg::ST_IDLE;
        end
      end
      amd_pkg::ST_IND_HI: begin
        if (mem_ack) begin
          hi_next = mem_rdata;
          maddr_next = maddr_reg + 15'(amd_pkg::AMD_ONE);
          st_next = amd_pkg::ST_IND_LO;
        end
      end
      amd_pkg::ST_IND_LO: begin
        if (mem_ack) begin
          // Post-indexing on the fetched fifteen-bit address
          ea_next = full + (idx_on_reg ? {7'h0, idx_reg} : 15'h0);
          if (mode == amd_pkg::AMD_M_ABR) begin
            page_next = full[14:13];
          end
          req_next = 1'b0;
          done_next = 1'b1;
          st_next = amd_pkg::ST_IDLE;
        end
      end
      default: st_next = amd_pkg::ST_IDLE;
    endcase
    // Accepted interrupt wins over a branch loading the page bits
    if (irq_acc) begin
      page_next = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= amd_pkg::ST_IDLE;
      instr_reg <= '0;
      pc_reg <= '0;
      bank_reg <= 1'b0;
      page_reg <= 2'h0;
      ea_reg <= '0;
      hi_reg <= '0;
      idx_reg <= '0;
      opa_reg <= '0;
      opb_reg <= '0;
      op_sel_reg <= '0;
      idx_sel_reg <= '0;
      idx_on_reg <= 1'b0;
      done_reg <= 1'b0;
      req_reg <= 1'b0;
      maddr_reg <= '0;
      gpr_sel_reg <= '0;
    end else begin
      st_reg <= st_next;
      instr_reg <= instr_next;
      pc_reg <= pc_next;
      bank_reg <= bank_next;
      page_reg <= page_next;
      ea_reg <= ea_next;
      hi_reg <= hi_next;
      idx_reg <= idx_next;
      opa_reg <= opa_next;
      opb_reg <= opb_next;
      op_sel_reg <= op_sel_next;
      idx_sel_reg <= idx_sel_next;
      idx_on_reg <= idx_on_next;
      done_reg <= done_next;
      req_reg <= req_next;
      maddr_reg <= maddr_next;
      gpr_sel_reg <= gpr_sel_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_rd_req = req_reg;
  assign mem_addr = maddr_reg;
  assign page_bits = page_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic calc_ok;
  assign calc_ok = (st_reg == amd_pkg::ST_CALC) & ~irq_acc;
  sequence s_hi_ack;
    st_reg == amd_pkg::ST_IND_HI && mem_ack;
  endsequence
  sequence s_lo_ack;
    st_reg == amd_pkg::ST_IND_LO && mem_ack;
  endsequence

  page_clear_a: assert property (irq_acc |=> page_reg == 2'h0)
    else $error("page bits not cleared by interrupt");
  page_hold_a: assert property (
    !irq_acc && mode != amd_pkg::AMD_M_ABR |=> $stable(page_reg))
    else $error("page bits changed without a long address");
  abr_page_a: assert property (calc_ok && mode == amd_pkg::AMD_M_ABR && !d.ind
    |=> page_reg == $past(instr_reg[14:13]) && ea_reg[14:13] == page_reg)
    else $error("branch did not load page bits");
  zrel_page_a: assert property (calc_ok && mode == amd_pkg::AMD_M_ZREL && !d.ind
    |=> ea_reg[14:13] == 2'h0 && ea_reg[6:0] == $past(instr_reg[14:8]))
    else $error("page zero target outside page 0");
  rel_page_a: assert property (st_reg == amd_pkg::ST_CALC && mode == amd_pkg::AMD_M_REL
    && !d.ind |=> ea_reg[14:13] == pc_reg[14:13] && done_reg)
    else $error("relative target left the page");
  idx_op_a: assert property (st_reg == amd_pkg::ST_CALC && mode == amd_pkg::AMD_M_ANB
    && d.idx_ctl != amd_pkg::AMD_IX_NONE |=> op_sel_reg == amd_pkg::AMD_R0 && idx_on_reg)
    else $error("indexed operand not register zero");
  inc_wb_a: assert property (st_reg == amd_pkg::ST_CALC && mode == amd_pkg::AMD_M_ANB
    && d.idx_ctl == amd_pkg::AMD_IX_INC |-> rf_we && rf_wdata == rf_a + amd_pkg::AMD_ONE)
    else $error("auto-increment not written back");
  ind_pair_a: assert property (s_hi_ack
    |=> mem_addr == $past(mem_addr) + 15'(amd_pkg::AMD_ONE) && mem_rd_req)
    else $error("second pointer byte not at next address");
  post_idx_a: assert property (s_lo_ack |=> done_reg
    && ea_reg == ({$past(hi_reg[6:0]), $past(mem_rdata)}
    + ($past(idx_on_reg) ? {7'h0, idx_reg} : 15'h0)))
    else $error("post-indexed address wrong");
  apb_wait_a: assert property (acc |=> pready ##1 !pready)
    else $error("APB answer not after one wait state");
endmodule
